// File: vsb_tx_fec.sv
/*
  Transmitter front end: scrambles transport payload, appends Reed-Solomon
  parity and convolutionally interleaves the data bytes, feeding a two-entry
  output buffer. Assumes a packet source on the same clock with valid/ready,
  and a downstream trellis coder and sync inserter that add the syncs.
*/
// Operation
// [RQ1] Segments are 832 symbols: four sync symbols, then data and parity.
// [RQ2] Terrestrial segment: sync byte, 187 payload bytes, 20 parity bytes.
// [RQ3] Terrestrial mode carries one 207-byte code block per segment.
// [RQ4] Cable mode carries two 207-byte code blocks per segment.
// [RQ5] A field is one field-sync segment and 312 data segments.
// [RQ6] Symbols carry three bits terrestrial, four bits cable.
// [RQ7] Only payload is scrambled; syncs and parity pass unchanged.
// [RQ8] Scrambling sequence comes from a 16-bit, 9-tap maximal register.
// [RQ9] Eight register outputs form a byte, XORed bit for bit, MSB to MSB.
// [RQ10] Register loads F180 in the sync slot before each field's first segment.
// [RQ11] First scrambling bytes after loading are C0, 6D, 3F.
// [RQ12] Sequence holds during parity and sync, resumes on next payload byte.
// [RQ13] A t=10 (207,187) code appends 20 parity bytes after the data.
// [RQ14] First serial bit becomes the most significant bit of each byte.
// [RQ15] Bytes are convolutionally interleaved over 52 branches.
// [RQ16] Only data bytes enter the interleaver, never the syncs.
// [RQ17] Source may burst; interleaver only advances on a present data byte.
// [RQ18] First data byte of each field enters the zero-delay branch.
// [RQ19] Commutator steps one branch per byte; each branch adds one increment.
// [RQ20] Scrambler taps and code polynomials follow the defining generators.
`timescale 1ns/1ps
module vsb_tx_fec
  import vsb_tx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       cable_mode,
  input  wire logic [7:0] in_data,
  input  wire logic       in_valid,
  output logic            in_ready,
  output logic [7:0]      out_data,
  output logic            out_valid,
  output logic            out_seg_start,
  output logic            out_field_start,
  input  wire logic       out_ready,
  output logic [2:0]      bits_per_symbol
);

  typedef struct packed {
    logic                      mode_meta;
    logic                      mode_pin;
    logic                      cable;
    logic                      in_ready;
    logic [7:0]                phase;
    logic                      pkt;
    logic [8:0]                seg;
    logic [15:0]               scrambling_sequence;
    logic [PAR_BYTES-1:0][7:0] par;
    logic [5:0]                br;
    logic [BRANCHES-1:0][7:0]  ptr;
    logic [IL_BYTES-1:0][7:0]  mem;
    logic [1:0]                cnt;
    elem_t [1:0]               q;
    logic [2:0]                bits;
    logic                      settle;
    logic                      valid;
  } state_t;

  // Eight sequence register taps that form the scrambling byte, MSB first.
  function automatic logic [7:0] prs_byte(input logic [15:0] s);
    return {s[13], s[14], s[11], s[10], s[6], s[3], s[2], s[0]}; // RQ9 RQ11
  endfunction

  function automatic logic [12:0] branch_base(input logic [5:0] b);
    return 13'(BRANCH_STEP * int'(b) * (int'(b) - 1) / 2);
  endfunction

  function automatic logic [7:0] branch_len(input logic [5:0] b);
    return 8'(BRANCH_STEP * int'(b));
  endfunction

  state_t r;
  state_t next_r;

  logic                      take;
  logic                      par_ph;
  logic                      space;
  logic                      push;
  logic                      pop;
  logic                      step;
  logic                      first;
  logic [7:0]                scr;
  logic [7:0]                fb;
  logic [7:0]                il_in;
  logic [7:0]                il_out;
  logic [5:0]                b;
  logic [12:0]               addr;
  elem_t                     elem;
  logic [PAR_BYTES-1:0][7:0] prod;

  // One multiplier per generator coefficient g0..g19.
  genvar gi;
  generate
    for (gi = 0; gi < PAR_BYTES; gi++)
    begin : g_mul
      assign prod[gi] = gf_mul(fb, RS_GEN[8*gi +: 8]); // RQ13 RQ20
    end
  endgenerate

  always_comb
  begin
    next_r = r;
    // The mode pin is asynchronous to this clock; two flops settle it
    // before the field-start latch reads it.
    next_r.mode_meta = cable_mode;
    next_r.mode_pin  = r.mode_meta;
    // Intake stays closed one extra cycle after reset, so the first field
    // latches the settled pin and not the reset value of the flops.
    next_r.settle    = 1'b1; // RQ4

    space  = r.cnt != BUF_DEPTH;
    pop    = (r.cnt != 2'h0) && out_ready;
    // The registered ready already includes the intake phase and space.
    take   = r.in_ready && in_valid; // RQ17
    par_ph = r.phase > PH_PAY_LAST;
    step   = take || (par_ph && space); // RQ17
    push   = (take && r.phase != PH_SYNC) || (par_ph && space); // RQ7 RQ16
    first  = (r.seg == 9'h000) && !r.pkt && (r.phase == PH_PAY_1ST);

    // Bytes arrive parallel with the first serial bit in bit 7.
    scr   = in_data ^ prs_byte(r.scrambling_sequence); // RQ9 RQ14
    fb    = scr ^ r.par[PAR_BYTES-1];
    il_in = par_ph ? r.par[PAR_BYTES-1] : scr; // RQ7 RQ13

    // Each branch but branch 0 is a circular buffer in the shared store; reading a slot
    // before rewriting it delays a byte by one revolution of that branch.
    // Forcing branch 0 at field start keeps the commutator field-locked.
    b      = first ? 6'h00 : r.br; // RQ18
    addr   = branch_base(b) + 13'(r.ptr[b]);
    il_out = (b == 6'h00) ? il_in : r.mem[addr]; // RQ15 RQ19

    elem.data        = il_out;
    elem.seg_start   = (r.phase == PH_PAY_1ST) && (!r.cable || !r.pkt); // RQ1
    elem.field_start = elem.seg_start && (r.seg == 9'h000);

    if (step)
    begin
      if (r.phase == PH_SYNC && r.seg == 9'h000 && !r.pkt)
      begin
        // Mode changes take effect only at a field boundary.
        next_r.scrambling_sequence   = PRS_INIT; // RQ10
        next_r.cable = r.mode_pin;
        next_r.bits  = r.mode_pin ? BITS_CABLE : BITS_TERR; // RQ6
      end
      else if (!par_ph && r.phase != PH_SYNC)
      begin
        // The sequence only moves on payload, which keeps it aligned with
        // the data however the source bursts.
        next_r.scrambling_sequence = {r.scrambling_sequence[14:0], 1'b0}
                   ^ (r.scrambling_sequence[15] ? PRS_POLY : 16'h0000); // RQ8 RQ12
        next_r.par[0] = prod[0];
        for (int j = 1; j < PAR_BYTES; j++)
          next_r.par[j] = r.par[j-1] ^ prod[j]; // RQ13
      end
      else if (par_ph)
      begin
        // Zeros refill the register as parity leaves it, so it is clean for
        // the next block without a separate clear.
        next_r.par[0] = 8'h00;
        for (int j = 1; j < PAR_BYTES; j++)
          next_r.par[j] = r.par[j-1];
      end

      if (push)
      begin
        if (b != 6'h00)
        begin
          next_r.mem[addr] = il_in; // RQ19
          next_r.ptr[b] = (r.ptr[b] == branch_len(b) - 8'h01)
                        ? 8'h00 : r.ptr[b] + 8'h01;
        end
        next_r.br = (b == BR_LAST) ? 6'h00 : b + 6'h01; // RQ19
      end

      if (r.phase == PH_LAST)
      begin
        next_r.phase = PH_SYNC;
        // Cable mode packs two code blocks into one segment.
        next_r.pkt = r.cable && !r.pkt; // RQ3 RQ4
        if (!r.cable || r.pkt)
          next_r.seg = (r.seg == SEG_LAST) ? 9'h000 : r.seg + 9'h001; // RQ5
      end
      else
        next_r.phase = r.phase + 8'h01; // RQ2
    end

    // The buffer absorbs downstream stalls; intake drops ready a cycle
    // ahead, so no byte is ever offered into a full buffer.
    case ({push, pop})
      2'b10:
      begin
        next_r.q[r.cnt[0]] = elem;
        next_r.cnt = r.cnt + 2'h1;
      end
      2'b01:
      begin
        next_r.q[0] = r.q[1];
        next_r.cnt = r.cnt - 2'h1;
      end
      2'b11:
      begin
        if (r.cnt == 2'h1)
          next_r.q[0] = elem;
        else
        begin
          next_r.q[0] = r.q[1];
          next_r.q[1] = elem;
        end
      end
      default:
      begin
        next_r.cnt = r.cnt;
      end
    endcase

    next_r.in_ready = (next_r.phase <= PH_PAY_LAST)
                    && (next_r.cnt != BUF_DEPTH)
                    && r.settle;
    next_r.valid    = next_r.cnt != 2'h0;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      r      <= '0;
      r.bits <= BITS_TERR;
    end
    else
      r <= next_r;
  end

  // Every output is a register bit, so no logic follows the flops.
  assign in_ready        = r.in_ready;
  assign out_data        = r.q[0].data;
  assign out_valid       = r.valid;
  assign out_seg_start   = r.q[0].seg_start;
  assign out_field_start = r.q[0].field_start;
  assign bits_per_symbol = r.bits;

  // Bytes pushed since the last segment start, for the length check.
  logic [9:0] seg_bytes;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      seg_bytes <= 10'h000;
    else if (push)
      seg_bytes <= elem.seg_start ? 10'h001 : seg_bytes + 10'h001;
  end

  // Payload bytes scrambled since the field's load, saturating at three.
  logic [1:0] pay_idx;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pay_idx <= 2'h0;
    else if (step && first)
      pay_idx <= 2'h1;
    else if (take && r.phase != PH_SYNC && pay_idx != 2'h0
             && pay_idx != 2'h3)
      pay_idx <= pay_idx + 2'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  prs_first_byte_a: assert property ( // RQ11
    step && first |-> prs_byte(r.scrambling_sequence) == PRS_FIRST)
    else $error("first scrambling byte of the field is wrong");

  prs_second_byte_a: assert property ( // RQ11
    pay_idx == 2'h1 |-> prs_byte(r.scrambling_sequence) == PRS_SECOND)
    else $error("second scrambling byte of the field is wrong");

  prs_third_byte_a: assert property ( // RQ11
    pay_idx == 2'h2 |-> prs_byte(r.scrambling_sequence) == PRS_THIRD)
    else $error("third scrambling byte of the field is wrong");

  prs_load_a: assert property ( // RQ10
    take && r.phase == PH_SYNC && r.seg == 9'h000 && !r.pkt
    |=> r.scrambling_sequence == PRS_INIT)
    else $error("sequence register not loaded at field start");

  prs_hold_a: assert property ( // RQ12
    par_ph |=> r.scrambling_sequence == $past(r.scrambling_sequence))
    else $error("sequence advanced during parity");

  sync_drop_a: assert property ( // RQ7
    take && r.phase == PH_SYNC |-> !push)
    else $error("transport sync byte entered the data path");

  seg_length_a: assert property ( // RQ3
    push && elem.seg_start && seg_bytes != 10'h000
    |-> seg_bytes == (r.cable ? 10'(2 * BLK_BYTES) : 10'(BLK_BYTES)))
    else $error("segment length does not match the mode");

  seg_range_a: assert property ( // RQ5
    r.seg <= SEG_LAST)
    else $error("segment index beyond last data segment");

  field_branch_a: assert property ( // RQ18
    push && first |-> il_out == il_in ##1 r.br == 6'h01)
    else $error("first field byte not on zero-delay branch");

  commutator_step_a: assert property ( // RQ19
    push && !first
    |=> r.br == (($past(r.br) == BR_LAST) ? 6'h00 : $past(r.br) + 6'h01))
    else $error("commutator did not step by one branch");

  stall_hold_a: assert property ( // RQ17
    !push |=> $stable(r.br))
    else $error("commutator moved without a data byte");

  out_hold_a: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output byte changed while stalled");

  buf_room_a: assert property ( // RQ17
    push |-> r.cnt != BUF_DEPTH)
    else $error("byte pushed into a full output buffer");

  mode_bits_a: assert property ( // RQ6
    bits_per_symbol == (r.cable ? BITS_CABLE : BITS_TERR))
    else $error("symbol width does not match the latched mode");

  out_field_a: assert property ( // RQ5
    out_field_start |-> out_seg_start)
    else $error("field start byte not marked as segment start");

  field_start_c: cover property (push && elem.field_start);
  buffer_full_c: cover property (r.cnt == BUF_DEPTH ##1 pop);
  parity_stall_c: cover property (par_ph && !space);
  cable_segment_c: cover property (push && elem.seg_start && r.cable);
  prs_seq_c: cover property (pay_idx == 2'h2);

endmodule // vsb_tx_fec

// File: vsb_tx_pkg.sv
/*
  Constants, types and Galois-field helpers for the broadcast transmitter
  front end (scrambler, Reed-Solomon parity, convolutional interleaver).
  Assumes a single 10 MHz clock domain; no registers reachable by software.
*/
package vsb_tx_pkg;

  localparam int CLK_MHZ      = 10;
  localparam int SEG_SYMBOLS  = 832;
  localparam int SYNC_SYMBOLS = 4;
  localparam int PAY_BYTES    = 187;
  localparam int PAR_BYTES    = 20;
  localparam int BLK_BYTES    = PAY_BYTES + PAR_BYTES;
  localparam int DATA_SEGS    = 312;
  localparam int BRANCHES     = 52;
  // Delay increment per interleaver branch, in bytes.
  localparam int BRANCH_STEP  = 4;
  localparam int IL_BYTES     = BRANCH_STEP * BRANCHES * (BRANCHES - 1) / 2;

  // Packet phase: 0 is the transport sync byte, then payload, then parity.
  localparam logic [7:0] PH_SYNC     = 8'h00;
  localparam logic [7:0] PH_PAY_1ST  = 8'h01;
  localparam logic [7:0] PH_PAY_LAST = 8'(PAY_BYTES);
  localparam logic [7:0] PH_LAST     = 8'(BLK_BYTES);
  localparam logic [8:0] SEG_LAST    = 9'(DATA_SEGS - 1);
  localparam logic [5:0] BR_LAST     = 6'(BRANCHES - 1);
  localparam logic [1:0] BUF_DEPTH   = 2'h2;

  localparam logic [15:0] PRS_INIT  = 16'hf180;
  // Feedback mask x^13+x^12+x^11+x^7+x^6+x^3+x+1 of the x^16 generator.
  localparam logic [15:0] PRS_POLY  = 16'h38cb;
  localparam logic [7:0]  PRS_FIRST = 8'hc0;
  localparam logic [7:0]  PRS_SECOND = 8'h6d;
  localparam logic [7:0]  PRS_THIRD  = 8'h3f;
  // Low byte of the field polynomial x^8+x^4+x^3+x^2+1.
  localparam logic [7:0]  GF_POLY   = 8'h1d;
  localparam logic [7:0]  GF_ALPHA  = 8'h02;
  localparam logic [2:0]  BITS_TERR  = 3'h3;
  localparam logic [2:0]  BITS_CABLE = 3'h4;

  typedef struct packed {
    logic [7:0] data;
    logic       seg_start;
    logic       field_start;
  } elem_t;

  function automatic logic [7:0] gf_mul(input logic [7:0] a,
                                        input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int k = 0; k < 8; k++)
    begin
      if (b[k]) p = p ^ x;
      x = {x[6:0], 1'b0} ^ (x[7] ? GF_POLY : 8'h00);
    end
    return p;
  endfunction

  // Coefficients g0..g19 of prod (x + alpha^i), i = 0..19; g20 is one.
  function automatic logic [8*PAR_BYTES-1:0] rs_gen();
    logic [7:0] g [0:PAR_BYTES];
    logic [7:0] root;
    logic [8*PAR_BYTES-1:0] res;
    for (int j = 0; j <= PAR_BYTES; j++) g[j] = 8'h00;
    g[0] = 8'h01;
    root = 8'h01;
    for (int i = 0; i < PAR_BYTES; i++)
    begin
      for (int j = i + 1; j > 0; j--) g[j] = g[j-1] ^ gf_mul(g[j], root);
      g[0] = gf_mul(g[0], root);
      root = gf_mul(root, GF_ALPHA);
    end
    for (int j = 0; j < PAR_BYTES; j++) res[8*j +: 8] = g[j];
    return res;
  endfunction

  localparam logic [8*PAR_BYTES-1:0] RS_GEN = rs_gen();

endpackage

// File: vsb_tx_src_model.sv
/*
  Transport packet source model: 188-byte packets, sync byte first, sent
  in random bursts over in_data/in_valid/in_ready.
  Assumes the same clock and active-low asynchronous reset as the design.
*/
`timescale 1ns/1ps
module vsb_tx_src_model
  import vsb_tx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       in_ready,
  input  wire logic       gap_en,
  output logic [7:0]      in_data,
  output logic            in_valid,
  output logic [7:0]      first_pay
);
  localparam logic [7:0] SYNC_BYTE = 8'h47;

  logic [7:0] idx;
  logic [7:0] nidx;
  logic       seen;

  assign nidx = !(in_valid && in_ready) ? idx :
                (idx == PH_PAY_LAST) ? PH_SYNC : idx + 8'h01;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      idx       <= PH_SYNC;
      in_valid  <= 1'b0;
      in_data   <= 8'h00;
      first_pay <= 8'h00;
      seen      <= 1'b0;
    end
    else
    begin
      idx <= nidx;
      if (in_valid && in_ready && idx == PH_PAY_1ST && !seen)
      begin
        first_pay <= in_data;
        seen      <= 1'b1;
      end
      // An offer is held until taken; only then may the source pause.
      if (!in_valid || in_ready)
      begin
        if (gap_en && $urandom_range(3) == 0)
        begin
          in_valid <= 1'b0;
          in_data  <= ~in_data;
        end
        else
        begin
          in_valid <= 1'b1;
          in_data  <= (nidx == PH_SYNC) ? SYNC_BYTE : 8'($urandom);
        end
      end
      else if (!in_valid)
        in_data <= ~in_data;
    end
  end
endmodule // vsb_tx_src_model

// File: vsb_tx_randomize_fec_interleave_tb_top.sv
/*
  Self-checking testbench for the transmitter front end: packet pacing,
  output segment marks, first scrambled bytes and interleaver start-up.
  Assumes the design's storage resets to zero and a 10 MHz clock.
*/
`timescale 1ns/1ps
module vsb_tx_randomize_fec_interleave_tb_top
  import vsb_tx_pkg::*;
;
  logic       clk;
  logic       rstn;
  logic       cable_mode;
  logic       in_valid;
  logic       in_ready;
  logic       out_valid;
  logic       out_seg_start;
  logic       out_field_start;
  logic       out_ready;
  logic       gap_en;
  logic       strict;
  logic       prev_rdy;
  logic [7:0] in_data;
  logic [7:0] out_data;
  logic [7:0] first_pay;
  logic [2:0] bits_per_symbol;
  int         failures;
  int         n_tests;
  int         k;
  int         seg_len;
  int         taken;
  int         lo_run;
  int         n_rises;
  int         n_in;
  logic [7:0] pay [1:2];

  vsb_tx_fec dut_u (.clk(clk), .rstn(rstn), .cable_mode(cable_mode),
    .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready),
    .out_data(out_data), .out_valid(out_valid),
    .out_seg_start(out_seg_start), .out_field_start(out_field_start),
    .out_ready(out_ready), .bits_per_symbol(bits_per_symbol));

  vsb_tx_src_model src_u (.clk(clk), .rstn(rstn), .in_ready(in_ready),
    .gap_en(gap_en), .in_data(in_data), .in_valid(in_valid),
    .first_pay(first_pay));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Storage starts at zero, so only branch 0 shows real data early on; the
  // second and third payload bytes return after four and eight commutator revolutions.
  localparam int DLY = BRANCH_STEP * BRANCHES;
  function automatic logic [7:0] exp_data(input int n, input logic [7:0] f);
    if (n == 0)
      return f ^ PRS_FIRST;
    if (n == 1 + DLY)
      return pay[1] ^ PRS_SECOND;
    if (n == 2 + 2 * DLY)
      return pay[2] ^ PRS_THIRD;
    return 8'h00;
  endfunction

  always @(posedge clk)
  begin
    if (!rstn)
    begin
      k        = 0;
      taken    = 0;
      lo_run   = 0;
      n_rises  = 0;
      n_in     = 0;
      prev_rdy = 1'b0;
    end
    else
    begin
      if (out_valid && out_ready)
      begin
        check("seg_start", 8'((k % seg_len) == 0), 8'(out_seg_start));
        check("field_start", 8'(k == 0), 8'(out_field_start));
        if (k < BRANCHES || k == 1 + DLY || k == 2 + 2 * DLY)
          check("out_data", exp_data(k, first_pay), out_data);
        k++;
      end
      if (strict && !in_ready && prev_rdy)
      begin
        check("bytes_taken", 8'(PAY_BYTES + 1), 8'(taken));
        taken = 0;
      end
      if (strict && in_ready && !prev_rdy)
      begin
        if (n_rises > 0)
          check("parity_gap", 8'(PAR_BYTES), 8'(lo_run));
        n_rises++;
        lo_run = 0;
      end
      if (in_valid && in_ready)
      begin
        if (n_in == 2 || n_in == 3)
          pay[n_in - 1] = in_data;
        n_in++;
        taken++;
      end
      if (!in_ready)
        lo_run++;
      prev_rdy = in_ready;
    end
  end

  task automatic run_test(input string name, input logic cab,
                          input int cycles);
    rstn       <= 1'b0;
    cable_mode <= cab;
    out_ready  <= 1'b1;
    gap_en     <= 1'b0;
    strict     <= 1'b1;
    seg_len    = cab ? 2 * BLK_BYTES : BLK_BYTES;
    repeat (4) @(posedge clk);
    check("reset_in_ready", 8'h00, 8'(in_ready));
    check("reset_out_valid", 8'h00, 8'(out_valid));
    check("reset_bits", 8'(BITS_TERR), 8'(bits_per_symbol));
    rstn <= 1'b1;
    // Pacing is only exact while the buffer never fills.
    repeat (3 * (BLK_BYTES + 1) + 40) @(posedge clk);
    strict <= 1'b0;
    gap_en <= 1'b1;
    repeat (cycles)
    begin
      @(posedge clk);
      out_ready <= ($urandom_range(3) != 0);
    end
    check("bits_per_symbol", 8'(cab ? BITS_CABLE : BITS_TERR),
          8'(bits_per_symbol));
    check("progress", 8'h01, 8'(k > 2 * seg_len));
    $display("test %s done", name);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    rstn       = 1'b0;
    cable_mode = 1'b0;
    out_ready  = 1'b0;
    gap_en     = 1'b0;
    strict     = 1'b0;
    seg_len    = BLK_BYTES;
    failures   = 0;
    n_tests    = 0;
    void'($urandom(32'hb0f8));
    @(posedge clk);
    run_test("terrestrial", 1'b0, 2500);
    run_test("cable", 1'b1, 4000);
    wrap_up();
  end

  // Both tests together need about 8000 cycles.
  initial
  begin
    #2_000_000;
    failures++;
    wrap_up();
  end
endmodule // vsb_tx_randomize_fec_interleave_tb_top
